// ### core/ldd_defs.svh
// Constants of the LED driver diagnostic sequencer
`ifndef LDD_DEFS_SVH
`define LDD_DEFS_SVH

// Channel count and shift word width
`define LDD_NCH        16
// Serial clock pulses that pick a report or diagnosis
`define LDD_SEL_TEMP   3'h0
`define LDD_SEL_OPEN   3'h1
`define LDD_SEL_SHORT  3'h2
`define LDD_SEL_DIAG   3'h3
`define LDD_CNT_MAX    3'h7
// Temperature report: upper bits fill with ones, flag in bit 0
`define LDD_TEMP_FILL  15'h7fff
`define LDD_TEMP_BIT   0
// Reset values
`define LDD_DATA_RST   16'h0000
`define LDD_SHIFT_RST  16'h0000
`define LDD_REP_RST    16'hffff
`define LDD_TEMP_RST   1'h1
`define LDD_CNT_RST    3'h0
// Output stagger: step between channels and clock period, in ns
`define LDD_STEP_NS    20
`define LDD_CLK_NS     50

`endif

// ### core/ldd_pkg.sv
// Types of the LED driver diagnostic sequencer
package ldd_pkg;

  // Diagnosis flow states
  typedef enum logic [2:0] {
    LDD_NORMAL,
    LDD_ARMED,
    LDD_TEST,
    LDD_DONE,
    LDD_WAIT
  } ldd_state_e;

  typedef logic [15:0] ldd_word_t;

endpackage

// ### core/ldd_edge.sv
// Edge detector for a synchronous input strobe
`timescale 1ns/1ps
module ldd_edge
  import ldd_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Watched signal and its edges
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);

  logic prev_q;
  logic prev_d;

  // Next value of the delayed copy
  always_comb begin
    prev_d = ce ? sig : prev_q;
  end

  // Delayed copy register
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= RST_VAL;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Edges qualified by the clock enable
  assign rise = ce & sig & ~prev_q;
  assign fall = ce & ~sig & prev_q;

endmodule

// ### core/ldd_stagger.sv
// Delayed turn-on stage for one sink channel
`timescale 1ns/1ps
module ldd_stagger
  import ldd_pkg::*;
#(
  parameter int DLY = 0
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Requested and delayed channel state
  input  wire logic en,
  output logic      out_q
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       out_d;

  // Turn-off takes one cycle, turn-on waits DLY+1 cycles
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (ce) begin
      if (!en) begin
        cnt_d = 3'h0;
        out_d = 1'b0;
      end else if (cnt_q == 3'(DLY)) begin
        out_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  // Delay state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 3'h0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  // Turn-on lag after request
  property p_stagger_on;
    @(posedge clk) disable iff (rst)
      ce && en && !out_q && cnt_q == 3'(DLY) |=> out_q;
  endproperty
  a_stagger_on: assert property (p_stagger_on)
    else $error("channel did not turn on after its delay");

endmodule

// ### core/ldd_seq.sv
// Shift chain, pattern store and diagnosis sequencer of the LED sink driver
`timescale 1ns/1ps
`include "ldd_defs.svh"
module ldd_seq
  import ldd_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Serial chain from the controller
  input  wire logic        serial_clk,
  input  wire logic        serial_data_in,
  input  wire logic        load_strobe,
  input  wire logic        output_enable_low,
  // Analog sensing, one means normal
  input  wire logic        temp_ok,
  input  wire logic [15:0] open_ok,
  input  wire logic [15:0] short_ok,
  // Serial chain to the next device
  output logic             serial_data_out,
  // Sink drive and current reduction
  output logic [15:0]      sink_output,
  output logic             reduced_test_current
);

  ldd_state_e state_q;
  ldd_state_e state_d;
  ldd_word_t  shift_q;
  ldd_word_t  shift_d;
  ldd_word_t  data_q;
  ldd_word_t  data_d;
  ldd_word_t  open_q;
  ldd_word_t  open_d;
  ldd_word_t  short_q;
  ldd_word_t  short_d;
  ldd_word_t  pat;
  ldd_word_t  drive;
  ldd_word_t  report;
  logic       temp_q;
  logic       temp_d;
  logic [2:0] count_q;
  logic [2:0] count_d;
  logic       rtc_q;
  logic       rtc_d;
  logic       sclk_rise;
  logic       ld_rise;
  logic       ld_fall;
  logic       oen_rise;
  logic       oen_fall;

  // Edge detectors of the controller strobes
  ldd_edge #(.RST_VAL(1'h0)) u_sclk (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .sig  (serial_clk),
    .rise (sclk_rise),
    .fall ()
  );
  ldd_edge #(.RST_VAL(1'h0)) u_ld (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .sig  (load_strobe),
    .rise (ld_rise),
    .fall (ld_fall)
  );
  ldd_edge #(.RST_VAL(1'h1)) u_oen (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .sig  (output_enable_low),
    .rise (oen_rise),
    .fall (oen_fall)
  );

  // all-ones pattern
  // Saved data in normal and restore wait, all ones while diagnosing,
  // so the first enabled cycle after the load fall that leaves LDD_DONE never flashes all ones
  assign pat   = (state_q == LDD_NORMAL || state_q == LDD_WAIT) ?
                 data_q : '1;
  assign drive = pat & {`LDD_NCH{~output_enable_low}};

  // Report picked by the pulse count
  always_comb begin
    unique case (count_q)
      `LDD_SEL_OPEN:  report = open_q;
      `LDD_SEL_SHORT: report = short_q;
      default:        report = {`LDD_TEMP_FILL, temp_q};
    endcase
  end

  // Next state of shift chain, stores and sequencer
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    data_d  = data_q;
    open_d  = open_q;
    short_d = short_q;
    temp_d  = temp_q;
    count_d = count_q;
    if (ce) begin
      if (!load_strobe) begin
        count_d = `LDD_CNT_RST;
      end else if (sclk_rise && count_q != `LDD_CNT_MAX) begin
        count_d = count_q + 3'h1;
      end
      if (sclk_rise && !load_strobe) begin
        shift_d = {serial_data_in, shift_q[15:1]};
      end
      // keep saved pattern
      // Latch the shifted pattern, but keep it while diagnosing
      if (ld_rise && state_q == LDD_NORMAL) begin
        data_d = shift_q;
      end
      if (oen_rise) begin
        temp_d  = temp_ok;
        open_d  = open_ok | ~pat;
        short_d = short_ok | ~pat;
      end
      if (ld_fall && count_q != `LDD_SEL_DIAG) begin
        shift_d = report;
      end
      unique case (state_q)
        LDD_NORMAL: begin
          if (ld_fall && count_q == `LDD_SEL_DIAG) begin
            state_d = LDD_ARMED;
          end
        end
        LDD_ARMED: begin
          if (oen_fall) begin
            state_d = LDD_TEST;
          end
        end
        LDD_TEST: begin
          if (oen_rise) begin
            state_d = LDD_DONE;
          end
        end
        LDD_DONE: begin
          if (ld_fall) begin
            state_d = LDD_WAIT;
          end
        end
        LDD_WAIT: begin
          if (!load_strobe && !output_enable_low) begin
            state_d = LDD_NORMAL;
          end
        end
      endcase
    end
  end

  // Reduced current only while the test runs
  always_comb begin
    rtc_d = (state_d == LDD_TEST);
  end

  // Sequencer and store registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= LDD_NORMAL;
      shift_q <= `LDD_SHIFT_RST;
      data_q  <= `LDD_DATA_RST;
      open_q  <= `LDD_REP_RST;
      short_q <= `LDD_REP_RST;
      temp_q  <= `LDD_TEMP_RST;
      count_q <= `LDD_CNT_RST;
      rtc_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      data_q  <= data_d;
      open_q  <= open_d;
      short_q <= short_d;
      temp_q  <= temp_d;
      count_q <= count_d;
      rtc_q   <= rtc_d;
    end
  end

  assign serial_data_out      = shift_q[0];
  assign reduced_test_current = rtc_q;

  for (genvar k = 0; k < `LDD_NCH; k++) begin : g_ch
    localparam int DLY =
      (k * `LDD_STEP_NS + `LDD_CLK_NS - 1) / `LDD_CLK_NS;
    ldd_stagger #(.DLY(DLY)) u_stg (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .en    (drive[k]),
      .out_q (sink_output[k])
    );
  end

  // Report load after strobe fall
  sequence s_ld_fall_cnt(int n);
    ce && ld_fall && count_q == 3'(n);
  endsequence

  property p_temp_default;
    @(posedge clk) disable iff (rst)
      s_ld_fall_cnt(0) |=> shift_q == {`LDD_TEMP_FILL, $past(temp_q)};
  endproperty
  a_temp_default: assert property (p_temp_default)
    else $error("temperature report not loaded");

  property p_open_sel;
    @(posedge clk) disable iff (rst)
      s_ld_fall_cnt(1) |=> shift_q == $past(open_q);
  endproperty
  a_open_sel: assert property (p_open_sel)
    else $error("open report not loaded");

  property p_short_sel;
    @(posedge clk) disable iff (rst)
      s_ld_fall_cnt(2) ##0 state_q == LDD_DONE
      |=> shift_q == $past(short_q) && state_q == LDD_WAIT;
  endproperty
  a_short_sel: assert property (p_short_sel)
    else $error("selection after test not taken");

  property p_untested_one;
    @(posedge clk) disable iff (rst)
      oen_rise |=> &(open_q | $past(pat)) && &(short_q | $past(pat));
  endproperty
  a_untested_one: assert property (p_untested_one)
    else $error("untested channel not reported as one");

  property p_all_ones;
    @(posedge clk) disable iff (rst)
      state_q == LDD_TEST |-> pat == '1 && rtc_q;
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("test pattern not all ones");

  property p_keep_saved;
    @(posedge clk) disable iff (rst)
      state_q != LDD_NORMAL |=> data_q == $past(data_q);
  endproperty
  a_keep_saved: assert property (p_keep_saved)
    else $error("saved pattern changed during diagnosis");

  property p_enter_diag;
    @(posedge clk) disable iff (rst)
      s_ld_fall_cnt(3) ##0 state_q == LDD_NORMAL |=> state_q == LDD_ARMED;
  endproperty
  a_enter_diag: assert property (p_enter_diag)
    else $error("three pulses did not arm diagnosis");

  sequence s_test_end;
    ce && state_q == LDD_TEST && oen_rise;
  endsequence

  property p_test_end;
    @(posedge clk) disable iff (rst)
      s_test_end |=> state_q == LDD_DONE && !reduced_test_current;
  endproperty
  a_test_end: assert property (p_test_end)
    else $error("test did not end on enable rise");

  property p_restore;
    @(posedge clk) disable iff (rst)
      ce && state_q == LDD_WAIT && !load_strobe && !output_enable_low
      |=> state_q == LDD_NORMAL && pat == data_q;
  endproperty
  a_restore: assert property (p_restore)
    else $error("saved pattern not restored");

  property p_lsb_out;
    @(posedge clk) disable iff (rst)
      ce && sclk_rise && !load_strobe && !ld_fall
      |=> serial_data_out == $past(shift_q[1]);
  endproperty
  a_lsb_out: assert property (p_lsb_out)
    else $error("serial output is not the shifted LSB");

  property p_temp_cap;
    @(posedge clk) disable iff (rst)
      oen_rise |=> temp_q == $past(temp_ok);
  endproperty
  a_temp_cap: assert property (p_temp_cap)
    else $error("temperature not captured on enable rise");

  property p_count_clear;
    @(posedge clk) disable iff (rst)
      ce && !load_strobe |=> count_q == 3'h0;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("pulse count not cleared");

endmodule

// ### bench/ldd_ctl_model.sv
// Display controller model driving the serial chain of the sequencer
`timescale 1ns/1ps
module ldd_ctl_model (
  // Clock
  input  wire logic clk,
  // Readback from the chain
  input  wire logic serial_data_out,
  // Serial chain and strobes
  output logic      serial_clk,
  output logic      serial_data_in,
  output logic      load_strobe,
  output logic      output_enable_low
);
  // Idle levels, matching the reset view of the edge detectors
  initial begin
    serial_clk = 1'h0;
    serial_data_in = 1'h1;
    load_strobe = 1'h0;
    output_enable_low = 1'h1;
  end

  task automatic shift16(input logic [15:0] w, output logic [15:0] r);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      serial_data_in = w[i];
      serial_clk = 1'h0;
      @(negedge clk);
      r[i] = serial_data_out;
      serial_clk = 1'h1;
    end
    @(negedge clk);
    serial_clk = 1'h0;
    // Released data line shows the inverse, not a stale copy
    serial_data_in = ~serial_data_in;
  endtask

  task automatic select(input int n);
    @(negedge clk);
    load_strobe = 1'h1;
    repeat (n) begin
      @(negedge clk);
      serial_clk = 1'h1;
      @(negedge clk);
      serial_clk = 1'h0;
    end
    @(negedge clk);
    load_strobe = 1'h0;
    repeat (2) @(negedge clk);
  endtask

  // Outputs enabled
  task automatic enable_on();
    @(negedge clk);
    output_enable_low = 1'h0;
  endtask

  task automatic enable_off();
    repeat (40) @(negedge clk);
    output_enable_low = 1'h1;
    repeat (2) @(negedge clk);
  endtask
endmodule

// ### bench/test_led_driver_diagnostic_sequencer.sv
// Self-checking testbench of the LED driver diagnostic sequencer
`timescale 1ns/1ps
module test_led_driver_diagnostic_sequencer;
  import ldd_pkg::*;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        temp_ok;
  logic [15:0] open_ok;
  logic [15:0] short_ok;
  logic        serial_clk;
  logic        serial_data_in;
  logic        load_strobe;
  logic        output_enable_low;
  logic        serial_data_out;
  logic [15:0] sink_output;
  logic        reduced_test_current;
  int          miscompares;
  int          samples_checked;

  // Device under test
  ldd_seq dut (
    .clk                  (clk),
    .rst                  (rst),
    .ce                   (ce),
    .serial_clk           (serial_clk),
    .serial_data_in       (serial_data_in),
    .load_strobe          (load_strobe),
    .output_enable_low    (output_enable_low),
    .temp_ok              (temp_ok),
    .open_ok              (open_ok),
    .short_ok             (short_ok),
    .serial_data_out      (serial_data_out),
    .sink_output          (sink_output),
    .reduced_test_current (reduced_test_current)
  );

  // Controller on the far side
  ldd_ctl_model ctl (
    .clk               (clk),
    .serial_data_out   (serial_data_out),
    .serial_clk        (serial_clk),
    .serial_data_in    (serial_data_in),
    .load_strobe       (load_strobe),
    .output_enable_low (output_enable_low)
  );

  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Quiet outputs after reset
  task automatic t_reset();
    check("sinks", sink_output, 16'h0000);
    check("sdo", {15'h0000, serial_data_out}, 16'h0000);
    check("rtc", {15'h0000, reduced_test_current}, 16'h0000);
  endtask

  // Staggered turn-on of an all-ones pattern
  task automatic t_stagger();
    ldd_word_t r;
    logic [15:0] m;
    ctl.shift16(16'hffff, r);
    ctl.select(0);
    ctl.enable_on();
    for (int c = 1; c <= 7; c++) begin
      @(negedge clk);
      for (int k = 0; k < 16; k++) m[k] = (1 + (2 * k + 4) / 5) <= c;
      check("stagger", sink_output, m);
    end
    ctl.enable_off();
    check("sinks off", sink_output, 16'h0000);
  endtask

  // On-the-fly reports for selection counts 0, 1, 2 and 4
  task automatic t_reports();
    ldd_word_t r;
    ldd_word_t exp_tab [4];
    int sel_tab [4];
    exp_tab = '{16'hfffe, 16'hfff0, 16'hfff5, 16'hfffe};
    sel_tab = '{0, 1, 2, 4};
    open_ok = 16'h0ff0;
    short_ok = 16'hfff5;
    temp_ok = 1'h0;
    ctl.shift16(16'h00ff, r);
    ctl.select(0);
    ctl.enable_on();
    ctl.enable_off();
    // Sensor recovers; the captured flag must stay
    temp_ok = 1'h1;
    for (int i = 0; i < 4; i++) begin
      ctl.select(sel_tab[i]);
      ctl.shift16(16'ha5c3, r);
      check("report", r, exp_tab[i]);
    end
    ctl.shift16(16'h0000, r);
    check("chain", r, 16'ha5c3);
  endtask

  // Low-current diagnosis with saved pattern
  task automatic t_diag();
    ldd_word_t r;
    short_ok = 16'h7ffe;
    ctl.shift16(16'h1234, r);
    ctl.select(3);
    ctl.enable_on();
    repeat (10) @(negedge clk);
    check("test pattern", sink_output, 16'hffff);
    check("rtc on", {15'h0000, reduced_test_current}, 16'h0001);
    ctl.enable_off();
    check("rtc off", {15'h0000, reduced_test_current}, 16'h0000);
    ctl.select(2);
    ctl.enable_on();
    @(negedge clk);
    check("restore start", sink_output, 16'h0000);
    repeat (10) @(negedge clk);
    check("restored", sink_output, 16'h1234);
    ctl.shift16(16'h0000, r);
    check("diag report", r, 16'h7ffe);
    ctl.enable_off();
  endtask

  // Main sequence
  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst = 1'h1;
    ce = 1'h1;
    temp_ok = 1'h1;
    open_ok = 16'hffff;
    short_ok = 16'hffff;
    repeat (8) @(negedge clk);
    rst = 1'h0;
    t_reset();
    t_stagger();
    t_reports();
    t_diag();
    end_of_test();
  end

  // Watchdog
  initial begin
    #2000000;
    miscompares++;
    end_of_test();
  end
endmodule
